// >>> verilog/ssf_consts.vh
// Offsets, field positions, reset values and timing counts of the serial status flag block.
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH

// Register byte addresses on the Avalon-MM slave.
`define SSF_OFS_STATUS      4'h0
`define SSF_OFS_DATA        4'h4
`define SSF_OFS_CONTROL     4'h8

// Status register bit positions.
`define SSF_BIT_TX_EMPTY    7
`define SSF_BIT_TX_DONE     6
`define SSF_BIT_RX_FULL     5
`define SSF_BIT_IDLE        4
`define SSF_BIT_OVERRUN     3
`define SSF_BIT_NOISE       2
`define SSF_BIT_FRAMING     1
`define SSF_BIT_PARITY      0

// Control register bit positions.
`define SSF_CTL_BREAK       0
`define SSF_CTL_TX_ON       1
`define SSF_CTL_NINE        2
`define SSF_CTL_PAR_ON      3
`define SSF_CTL_PAR_ODD     4
`define SSF_CTL_IDLE_STOP   5
`define SSF_CTL_LONG_BRK    6

// Reset values.
`define SSF_RST_STATUS      8'hc0
`define SSF_RST_CONTROL     8'h00

// Frame lengths in bit times, start and stop included.
`define SSF_FRAME_SHORT     4'ha
`define SSF_FRAME_LONG      4'hb

// Oversampling: samples per bit and the sample windows.
`define SSF_OVS_LAST        4'hf
`define SSF_START_FIRST     4'h3
`define SSF_START_LAST      4'h9
`define SSF_BIT_FIRST       4'h7
`define SSF_BIT_LAST        4'h9
`define SSF_STOP_DONE       4'ha

// Clock and line rate; one oversample tick every SSF_OVS_DIV clocks.
`define SSF_CLOCK_HZ        10000000
`define SSF_BAUD_HZ         9600
`define SSF_OVS_PER_BIT     16
`define SSF_OVS_DIV         (`SSF_CLOCK_HZ / (`SSF_BAUD_HZ * `SSF_OVS_PER_BIT))

`endif

// >>> verilog/ssf_top.v
// Serial status flags with a compact transmitter, receiver and Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"
// Function
// - Eight read-only flags; writes ignored, sequences clear.
// - Transmit empty sets on reset and buffer move.
// - Status read then data write clears empty.
// - Complete sets on reset and when transmitter quiet.
// - Read then data, preamble or break clears complete.
// - Receive full sets when character enters register.
// - Status read then data read clears full.
// - Idle sets after one high character time.
// - Select zero: count starts after start bit.
// - Status read then data read clears idle.
// - Idle rearms only after new received character.
// - Overrun sets on unread data; new character dropped.
// - Status read then data read clears overrun.
// - Disagreeing samples set noise with receive full.
// - Status read then data read clears noise.
// - Zero stop bit sets framing with full.
// - Status read then data read clears framing.
// - Parity mismatch sets parity error with full.
// - Status read then data read clears parity.
// - Parity type zero even, one odd.
// - Long break detect blocks framing and full.
module ssf_top (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire        rx_pin,
	output reg         tx_pin
);

	localparam [3:0] RX_IDLE  = 4'h1;
	localparam [3:0] RX_START = 4'h2;
	localparam [3:0] RX_DATA  = 4'h4;
	localparam [3:0] RX_STOP  = 4'h8;
	localparam integer OVS_DIV = `SSF_OVS_DIV;
	localparam [6:0] OVS_LAST = OVS_DIV[6:0] - 7'h01;

	// Majority of three samples given as a count of ones.
	function maj_of;
		input [2:0] ones;
		maj_of = (ones >= 3'h2);
	endfunction

	// True when the samples of a bit do not all agree.
	function mixed_of;
		input [2:0] ones;
		input [2:0] total;
		mixed_of = (ones != 3'h0) && (ones != total);
	endfunction

	reg        rst_s1;
	reg        rst_s2;
	wire       rst_ok_n = rst_s2;
	reg        rx_s1;
	reg        rx_s2;
	reg        rx_s3;
	reg        rx_line;
	reg  [7:0] status;
	reg  [7:0] control;
	reg  [7:0] armed;
	reg  [8:0] rx_data;
	reg  [6:0] div_cnt;
	reg        tick;
	reg  [3:0] rx_state;
	reg  [3:0] rx_phase;
	reg  [3:0] rx_bitn;
	reg  [2:0] rx_ones;
	reg        rx_noise;
	reg  [8:0] rx_shift;
	reg  [3:0] idle_phase;
	reg  [3:0] idle_bits;
	reg        idle_ready;
	reg  [8:0] tx_buf;
	reg        tx_buf_valid;
	reg  [10:0] tx_shift;
	reg  [3:0] tx_left;
	reg  [3:0] tx_phase;
	reg        tx_busy;
	reg        pre_pend;
	reg        brk_pend;
	reg        char_done;
	reg        char_noise;
	reg        char_frame;
	reg  [8:0] char_data;
	reg  [7:0] next_status;
	reg  [7:0] clr_mask;
	reg  [7:0] set_mask;

	wire       acc_req     = avs_read | avs_write;
	wire       acc_go      = acc_req & ~avs_waitrequest;
	wire       hit_status  = (avs_address == `SSF_OFS_STATUS);
	wire       hit_data    = (avs_address == `SSF_OFS_DATA);
	wire       hit_control = (avs_address == `SSF_OFS_CONTROL);
	wire       rd_status   = acc_go & avs_read & hit_status;
	wire       rd_data     = acc_go & avs_read & hit_data;
	wire       wr_data     = acc_go & avs_write & hit_data & avs_byteenable[0];
	wire       wr_control  = acc_go & avs_write & hit_control & avs_byteenable[0];
	wire       nine        = control[`SSF_CTL_NINE];
	wire [3:0] frame_len   = nine ? `SSF_FRAME_LONG : `SSF_FRAME_SHORT;
	wire       wr_pre      = wr_control & ~control[`SSF_CTL_TX_ON]
	                         & avs_writedata[`SSF_CTL_TX_ON];
	wire       wr_brk      = wr_control & avs_writedata[`SSF_CTL_BREAK];
	wire       tx_quiet    = ~tx_buf_valid & ~tx_busy & ~pre_pend & ~brk_pend
	                         & ~control[`SSF_CTL_BREAK];
	wire       tx_start    = ~tx_busy & control[`SSF_CTL_TX_ON]
	                         & (pre_pend | brk_pend | control[`SSF_CTL_BREAK] | tx_buf_valid);
	wire       use_data    = ~pre_pend & ~brk_pend & ~control[`SSF_CTL_BREAK];
	wire       par_bit9    = (^tx_buf[7:0]) ^ control[`SSF_CTL_PAR_ODD];
	wire       par_bit8    = (^tx_buf[6:0]) ^ control[`SSF_CTL_PAR_ODD];
	wire [10:0] data_frame = nine
	                         ? {1'b1, control[`SSF_CTL_PAR_ON] ? par_bit9 : tx_buf[8],
	                            tx_buf[7:0], 1'b0}
	                         : {2'b11, control[`SSF_CTL_PAR_ON] ? par_bit8 : tx_buf[7],
	                            tx_buf[6:0], 1'b0};
	wire       par_bad     = control[`SSF_CTL_PAR_ON]
	                         & ((nine ? ^char_data[8:0] : ^char_data[7:0])
	                            != control[`SSF_CTL_PAR_ODD]);
	wire       idle_count  = rx_line & ~(control[`SSF_CTL_IDLE_STOP] & (rx_state != RX_IDLE));

	// Reset release through two flip-flops.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	// Receive pin passes three flip-flops; the line moves when the last two agree.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			rx_s1   <= 1'b1;
			rx_s2   <= 1'b1;
			rx_s3   <= 1'b1;
			rx_line <= 1'b1;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_line <= rx_s3;
			end
		end
	end

	// Oversample tick, sixteen per bit time.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			div_cnt <= 7'h00;
			tick    <= 1'b0;
		end else begin
			tick    <= (div_cnt == OVS_LAST);
			div_cnt <= (div_cnt == OVS_LAST) ? 7'h00 : div_cnt + 7'h01;
		end
	end

	// Avalon slave: one wait cycle, read data loaded as waitrequest falls.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~(acc_req & avs_waitrequest);
			if (avs_read & avs_waitrequest) begin
				case (avs_address)
					`SSF_OFS_STATUS:  avs_readdata <= {24'h000000, status};
					`SSF_OFS_DATA:    avs_readdata <= {23'h000000, rx_data};
					`SSF_OFS_CONTROL: avs_readdata <= {24'h000000, control};
					default:          avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Control register; a status read records which flags software saw set.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			control <= `SSF_RST_CONTROL;
			armed   <= 8'h00;
		end else begin
			if (wr_control) begin
				control <= {1'b0, avs_writedata[6:0]};
			end
			armed <= rd_status ? avs_readdata[7:0] : (armed & ~clr_mask);
		end
	end

	// Receiver: seven start samples, three per data and stop bit.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			rx_state   <= RX_IDLE;
			rx_phase   <= 4'h0;
			rx_bitn    <= 4'h0;
			rx_ones    <= 3'h0;
			rx_noise   <= 1'b0;
			rx_shift   <= 9'h000;
			char_done  <= 1'b0;
			char_noise <= 1'b0;
			char_frame <= 1'b0;
			char_data  <= 9'h000;
		end else begin
			char_done <= 1'b0;
			if (tick) begin
				rx_phase <= rx_phase + 4'h1;
				case (rx_state)
					RX_IDLE: begin
						rx_phase <= 4'h1;
						rx_ones  <= 3'h0;
						rx_noise <= 1'b0;
						if (!rx_line) begin
							rx_state <= RX_START;
						end
					end
					RX_START: begin
						if (rx_phase >= `SSF_START_FIRST && rx_phase <= `SSF_START_LAST) begin
							rx_ones <= rx_ones + {2'b00, rx_line};
						end
						if (rx_phase == `SSF_OVS_LAST) begin
							rx_ones  <= 3'h0;
							rx_bitn  <= 4'h0;
							rx_noise <= mixed_of(rx_ones, 3'h7);
							rx_state <= (rx_ones >= 3'h4) ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rx_phase >= `SSF_BIT_FIRST && rx_phase <= `SSF_BIT_LAST) begin
							rx_ones <= rx_ones + {2'b00, rx_line};
						end
						if (rx_phase == `SSF_OVS_LAST) begin
							rx_ones  <= 3'h0;
							rx_shift <= {maj_of(rx_ones), rx_shift[8:1]};
							rx_noise <= rx_noise | mixed_of(rx_ones, 3'h3);
							rx_bitn  <= rx_bitn + 4'h1;
							if (rx_bitn == (nine ? 4'h8 : 4'h7)) begin
								rx_state <= RX_STOP;
							end
						end
					end
					RX_STOP: begin
						if (rx_phase >= `SSF_BIT_FIRST && rx_phase <= `SSF_BIT_LAST) begin
							rx_ones <= rx_ones + {2'b00, rx_line};
						end
						if (rx_phase == `SSF_STOP_DONE) begin
							char_done  <= 1'b1;
							char_noise <= rx_noise | mixed_of(rx_ones, 3'h3);
							char_frame <= ~maj_of(rx_ones);
							char_data  <= nine ? rx_shift : {1'b0, rx_shift[8:1]};
							rx_state   <= RX_IDLE;
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Idle detector counts high bit times; stop-bit select clears it during frames.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			idle_phase <= 4'h0;
			idle_bits  <= 4'h0;
		end else if (!idle_count) begin
			idle_phase <= 4'h0;
			idle_bits  <= 4'h0;
		end else if (tick) begin
			idle_phase <= idle_phase + 4'h1;
			if (idle_phase == `SSF_OVS_LAST && idle_bits != frame_len) begin
				idle_bits <= idle_bits + 4'h1;
			end
		end
	end

	// Transmitter: buffer, shifter, queued preamble and break characters.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			tx_buf       <= 9'h000;
			tx_buf_valid <= 1'b0;
			tx_shift     <= 11'h7ff;
			tx_left      <= 4'h0;
			tx_phase     <= 4'h0;
			tx_busy      <= 1'b0;
			pre_pend     <= 1'b0;
			brk_pend     <= 1'b0;
			tx_pin       <= 1'b1;
		end else begin
			if (wr_data) begin
				tx_buf       <= {avs_byteenable[1] & avs_writedata[8], avs_writedata[7:0]};
				tx_buf_valid <= 1'b1;
			end else if (tx_start && use_data) begin
				tx_buf_valid <= 1'b0;
			end
			pre_pend <= wr_pre | (pre_pend & ~tx_start);
			brk_pend <= wr_brk | (brk_pend & ~(tx_start & ~pre_pend));
			if (tx_start) begin
				tx_busy  <= 1'b1;
				tx_phase <= 4'h0;
				tx_left  <= frame_len;
				if (pre_pend) begin
					tx_shift <= 11'h7ff;
				end else if (brk_pend || control[`SSF_CTL_BREAK]) begin
					tx_shift <= 11'h000;
				end else begin
					tx_shift <= data_frame;
				end
			end else if (tx_busy && tick) begin
				tx_phase <= tx_phase + 4'h1;
				if (tx_phase == `SSF_OVS_LAST) begin
					tx_shift <= {1'b1, tx_shift[10:1]};
					tx_left  <= tx_left - 4'h1;
					if (tx_left == 4'h1) begin
						tx_busy <= 1'b0;
					end
				end
			end
			tx_pin <= tx_busy ? tx_shift[0] : 1'b1;
		end
	end

	// Flag set and clear terms; a set in the clearing cycle wins.
	always @* begin
		set_mask = 8'h00;
		clr_mask = 8'h00;
		if (tx_start && use_data) begin
			set_mask[`SSF_BIT_TX_EMPTY] = 1'b1;
		end
		if (tx_quiet && !wr_data && !wr_pre && !wr_brk) begin
			set_mask[`SSF_BIT_TX_DONE] = 1'b1;
		end
		if (char_done) begin
			if (status[`SSF_BIT_RX_FULL]) begin
				set_mask[`SSF_BIT_OVERRUN] = 1'b1;
			end else if (!control[`SSF_CTL_LONG_BRK]) begin
				set_mask[`SSF_BIT_RX_FULL] = 1'b1;
				set_mask[`SSF_BIT_NOISE]   = char_noise;
				set_mask[`SSF_BIT_FRAMING] = char_frame;
				set_mask[`SSF_BIT_PARITY]  = par_bad;
			end
		end
		if (idle_ready && tick && idle_count && idle_phase == `SSF_OVS_LAST
		    && idle_bits == frame_len - 4'h1) begin
			set_mask[`SSF_BIT_IDLE] = 1'b1;
		end
		if (wr_data) begin
			clr_mask[`SSF_BIT_TX_EMPTY] = armed[`SSF_BIT_TX_EMPTY];
		end
		if (wr_data || wr_pre || wr_brk) begin
			clr_mask[`SSF_BIT_TX_DONE] = armed[`SSF_BIT_TX_DONE];
		end
		if (rd_data) begin
			clr_mask[5:0] = armed[5:0];
		end
		next_status = set_mask | (status & ~clr_mask);
	end

	// Status register; bus writes never reach it.
	always @(posedge clock or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			status     <= `SSF_RST_STATUS;
			rx_data    <= 9'h000;
			idle_ready <= 1'b0;
		end else begin
			status <= next_status;
			if (set_mask[`SSF_BIT_RX_FULL]) begin
				rx_data    <= char_data;
				idle_ready <= 1'b1;
			end else if (set_mask[`SSF_BIT_IDLE]) begin
				idle_ready <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// >>> tb/ssf_top_monitor.sv
// Checker of the bus handshake and of the status flag relations at the top ports.
`timescale 1ns/1ps
`default_nettype none
module ssf_top_monitor (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A read result is taken at the edge where waitrequest is seen low.
	wire logic done_rd = avs_read && !avs_waitrequest;
	wire logic stat_rd = done_rd && avs_address == 4'h0;
	wire logic bad_rd = done_rd && avs_address != 4'h0 && avs_address != 4'h4 && avs_address != 4'h8;
	a_wait_answers:
		assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in the next cycle");
	a_wait_one_cycle:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_idle_wait_high:
		assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest fell without a request");
	a_rdata_hold:
		assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	a_status_width:
		assert property (stat_rd |-> avs_readdata[31:8] == 24'h0)
		else $error("status read shows bits above the eight flags");
	a_unmapped_zero:
		assert property (bad_rd |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_error_with_full:
		assert property (stat_rd && avs_readdata[2:0] != 3'h0 |-> avs_readdata[5])
		else $error("receive error flag without receive full");
	a_done_needs_empty:
		assert property (stat_rd && avs_readdata[6] |-> avs_readdata[7])
		else $error("transmit complete while buffer full");
endmodule
bind ssf_top ssf_top_monitor mon (
	.clock(clock),
	.rst_n(rst_n),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

// >>> tb/ssf_node.sv
// Remote serial node: sends frames on the receive line and decodes the transmit line.
`timescale 1ns/1ps
`default_nettype none
module ssf_node #(
	parameter int OVS = 65
) (
	input  wire logic       clock,
	input  wire logic       tx_line,
	output var  logic       rx_line,
	output var  logic [7:0] got,
	output var  logic       got_stb
);
	localparam int BIT = 16 * OVS;
	logic [8:0] b;
	initial begin
		rx_line = 1'b1;
		got = 8'h00;
		got_stb = 1'b0;
	end
	// One frame LSB first; stop gives the stop level, g flips the middle sample of bit g.
	task automatic send(input logic [7:0] d, input logic stop, input int g);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			if (i == g) begin
				repeat (8 * OVS) @(posedge clock);
				rx_line <= ~f[i];
				repeat (OVS) @(posedge clock);
				rx_line <= f[i];
				repeat (BIT - 9 * OVS) @(posedge clock);
			end else begin
				repeat (BIT) @(posedge clock);
			end
		end
		rx_line <= 1'b1;
	endtask
	// Each character on the transmit line is sampled mid-bit and handed on with a strobe.
	initial forever begin
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			b[i] = tx_line;
			repeat (BIT) @(posedge clock);
		end
		got <= b[8:1];
		got_stb <= 1'b1;
		@(posedge clock);
		got_stb <= 1'b0;
	end
endmodule
`default_nettype wire

// >>> tb/ssf_top_bench.sv
// Self-checking bench: registers, transmit to the node and receive flag sequences.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"
module ssf_top_bench;
	logic        clock;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rx_pin;
	logic        tx_pin;
	logic [7:0]  got;
	logic        got_stb;
	logic [63:0] qr[$];
	logic [7:0]  qt[$];
	logic [63:0] ex;
	logic [31:0] r;
	logic [7:0]  v;
	int          fails;
	int          n_compared;
	int          cyc;
	ssf_top uut (
		.clock(clock),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'hf),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.rx_pin(rx_pin),
		.tx_pin(tx_pin)
	);
	ssf_node #(.OVS(`SSF_OVS_DIV)) node (
		.clock(clock),
		.tx_line(tx_pin),
		.rx_line(rx_pin),
		.got(got),
		.got_stb(got_stb)
	);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic end_sim;
		if (qt.size() > 0) fails++;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] x);
		n_compared++;
		if (x !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, x);
		end
	endtask
	// One bus access: held until waitrequest is seen low, released after that edge.
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		qr.push_back({m, e});
		acc(1'b0, a, 32'h0);
	endtask
	task automatic st(input logic [31:0] e);
		rd(`SSF_OFS_STATUS, 32'hffffffff, e);
	endtask
	task automatic poll(input int b);
		do rd(`SSF_OFS_STATUS, 32'h0, 32'h0); while (r[b] !== 1'b1);
	endtask
	// The oldest note meets each read result and each character the node decodes.
	always @(posedge clock) begin
		if (avs_read && avs_waitrequest === 1'b0 && qr.size() > 0) begin
			ex = qr.pop_front();
			chk("readdata", ex[31:0], ex[63:32] & avs_readdata);
		end
		if (got_stb === 1'b1 && qt.size() > 0) chk("tx character", {24'h0, qt.pop_front()}, {24'h0, got});
		cyc++;
		if (cyc == 95000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		void'($urandom(46039));
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		st(32'hc0);
		acc(1'b1, `SSF_OFS_STATUS, 32'hff);
		st(32'hc0);
		rd(4'hc, 32'hffffffff, 32'h0);
		$display("test registers done");
		// Preamble request clears complete; a data write clears empty while it runs.
		v = 8'($urandom);
		qt.push_back(v);
		st(32'hc0);
		acc(1'b1, `SSF_OFS_CONTROL, 32'h02);
		st(32'h80);
		acc(1'b1, `SSF_OFS_DATA, {24'h0, v});
		st(32'h00);
		poll(`SSF_BIT_TX_DONE);
		st(32'hc0);
		$display("test transmit done");
		// A noisy character, then the idle line and its one-shot behaviour.
		node.send(8'h3c, 1'b1, 3);
		st(32'he4);
		rd(`SSF_OFS_DATA, 32'hffffffff, 32'h3c);
		st(32'hc0);
		poll(`SSF_BIT_IDLE);
		st(32'hd0);
		rd(`SSF_OFS_DATA, 32'hffffffff, 32'h3c);
		st(32'hc0);
		repeat (12480) @(posedge clock);
		st(32'hc0);
		$display("test receive idle done");
		// Bad stop and wrong even parity, then an overrun that drops the second character.
		acc(1'b1, `SSF_OFS_CONTROL, 32'h0a);
		node.send(8'hd5, 1'b0, -1);
		st(32'he3);
		node.send(8'h41, 1'b1, -1);
		st(32'heb);
		rd(`SSF_OFS_DATA, 32'h7f, 32'h55);
		st(32'hc0);
		// Long break detect on: a character with a low stop sets neither full nor framing.
		acc(1'b1, `SSF_OFS_CONTROL, 32'h42);
		node.send(8'h00, 1'b0, -1);
		st(32'hc0);
		$display("test receive errors done");
		end_sim();
	end
endmodule
`default_nettype wire
